// ### hdl/lec_cfg.svh
/*
 * Offsets, field positions, reset values and sizes for the lookup engine control block.
 * Assumes it is included by bare name wherever the constants are needed.
 */
`ifndef LEC_CFG_SVH
`define LEC_CFG_SVH

// =============================================================
// register indexes (byte address is index times four)
`define LEC_IDX_W        10
`define LEC_CTL1_IDX     10'h311
`define LEC_CTL2_IDX     10'h312
`define LEC_MSEL_IDX     10'h31F

// =============================================================
// control one fields
`define LEC_B_LEARN_DIS  7
`define LEC_B_SELF_FILT  6
`define LEC_B_FLUSH_TBL  5
`define LEC_B_FLUSH_MSTP 4
`define LEC_B_MC_SA_FWD  3
`define LEC_B_AGE_EN     2
`define LEC_B_FAST_AGE   1
`define LEC_B_LINK_FLUSH 0
`define LEC_CTL1_RST     8'h0C
// table settings out of reset: learning on, aging on, fast aging off
`define LEC_CFG_RST      3'h6

// =============================================================
// control two fields
`define LEC_CTL2_RST     8'h00
`define LEC_SCOPE_LO     2
`define LEC_SCOPE_NONE   2'h0
`define LEC_SCOPE_DYN    2'h1
`define LEC_SCOPE_STAT   2'h2
`define LEC_SCOPE_BOTH   2'h3

// =============================================================
// sizes
`define LEC_SA_MC_BIT    40
`define LEC_PORTS        8
`define LEC_PORT_W       3
`define LEC_ENT_W        12
`define LEC_ENTRIES      4096
`define LEC_MSTI_W       4
`define LEC_ADDR_W       12

`endif

// ### hdl/lec_pkg.sv
/*
 * Types shared by the lookup engine control block.
 * Assumes lec_cfg.svh is on the include path.
 */
`include "lec_cfg.svh"

package lec_pkg;

	// =============================================================
	// walk state and flush kind
	typedef enum logic [0:0] {LEC_IDLE, LEC_WALK} lec_state_e;
	typedef enum logic [1:0] {LEC_K_TBL, LEC_K_MSTP, LEC_K_LINK} lec_kind_e;

	// =============================================================
	// packet source check request and answer
	typedef struct packed {
		logic                   valid;
		logic [`LEC_PORT_W-1:0] port;
		logic [47:0]            sa;
	} lec_pkt_s;

	typedef struct packed {
		logic valid;
		logic drop;
		logic learn;
	} lec_chk_s;

	// =============================================================
	// flush step offered to the lookup table
	typedef struct packed {
		logic                   valid;
		logic [`LEC_ENT_W-1:0]  idx;
		logic                   dyn;
		logic                   stat;
		logic                   by_msti;
		logic [`LEC_MSTI_W-1:0] msti;
		logic                   by_port;
		logic [`LEC_PORTS-1:0]  ports;
	} lec_fl_s;

	// =============================================================
	// static settings for the table logic
	typedef struct packed {
		logic learn_en;
		logic age_en;
		logic fast_age;
	} lec_cfg_s;

endpackage

// ### hdl/lec_ctrl_one.sv
/*
 * Lookup engine control one register with its flush walker, source address
 * checks and aging settings, reached over an Avalon-MM slave with waitrequest.
 * Trigger bits read back as busy until their walk is over.
 * Assumes the lookup table accepts one flush step per i_flush_ack and that
 * packet, link and MAC inputs are synchronous to i_mclk.
 */
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
`include "lec_cfg.svh"

// What this block does
// R1 - bit 7 set stops unicast learning; reset value 0 keeps learning on
// R2 - bit 6 set drops packets whose source equals own MAC address
// R3 - self filtering only on ports with their enable; bit 6 clear filters none
// R4 - writing 1 to bit 5 flushes the table; clears itself when done
// R5 - both flushes take dynamic, static or both from the flush scope field
// R6 - whole table flush must not touch a separate static table; conflict noted
// R7 - writing 1 to bit 4 flushes entries of selected spanning tree instance
// R8 - bit 3 clear drops multicast source packets; default 1 forwards them
// R9 - bit 2 enables aging of dynamic entries; reset value 1
// R10 - bit 1 set selects fast aging; default 0 is normal aging
// R11 - bit 0 set flushes entries of ports whose link goes down
// R12 - scope 00 none, 01 dynamic, 10 static, 11 both
// R13 - trigger bit reads 1 while its flush runs, 0 once finished
module lec_ctrl_one
#(
	parameter int ENTRIES = `LEC_ENTRIES
)
(
	input  wire logic                   i_mclk,
	input  wire logic                   i_nrst,
	input  wire logic [`LEC_ADDR_W-1:0] i_address,
	input  wire logic                   i_read,
	input  wire logic                   i_write,
	input  wire logic [3:0]             i_byteenable,
	input  wire logic [31:0]            i_writedata,
	output      logic [31:0]            o_readdata,
	output      logic                   o_waitrequest,
	input  wire logic [47:0]            i_self_mac,
	input  wire logic [`LEC_PORTS-1:0]  i_sa_filt_port_en,
	input  wire logic [`LEC_PORTS-1:0]  i_link_down,
	input  wire lec_pkg::lec_pkt_s      i_pkt,
	output      lec_pkg::lec_chk_s      o_chk,
	output      lec_pkg::lec_cfg_s      o_cfg,
	output      lec_pkg::lec_fl_s       o_flush,
	input  wire logic                   i_flush_ack
);

	localparam logic [`LEC_ENT_W-1:0] LAST_IDX = `LEC_ENT_W'(ENTRIES - 1);

	// =============================================================
	// helpers

	// address hit on a register index
	function automatic logic lec_hit(input logic [`LEC_ADDR_W-1:0] a, input logic [`LEC_IDX_W-1:0] idx);
		lec_hit = (a == {idx, 2'b00});
	endfunction

	// scope code to entry kinds: bit 1 static, bit 0 dynamic; 00 removes nothing
	function automatic logic [1:0] lec_scope_kinds(input logic [1:0] sc);
		lec_scope_kinds = {(sc == `LEC_SCOPE_STAT) | (sc == `LEC_SCOPE_BOTH),
		                   (sc == `LEC_SCOPE_DYN) | (sc == `LEC_SCOPE_BOTH)};
	endfunction

	// =============================================================
	// state

	// software visible registers
	logic [7:0]                  ctl1_reg;
	logic [7:0]                  ctl1_next;
	logic [7:0]                  ctl2_reg;
	logic [7:0]                  ctl2_next;
	logic [`LEC_MSTI_W-1:0]      msel_reg;
	logic [`LEC_MSTI_W-1:0]      msel_next;
	// flush bookkeeping
	logic                        tbl_pend_reg;
	logic                        tbl_pend_next;
	logic                        mstp_pend_reg;
	logic                        mstp_pend_next;
	logic [`LEC_PORTS-1:0]       ld_pend_reg;
	logic [`LEC_PORTS-1:0]       ld_pend_next;
	lec_pkg::lec_state_e         st_reg;
	lec_pkg::lec_state_e         st_next;
	lec_pkg::lec_kind_e          kind_reg;
	lec_pkg::lec_kind_e          kind_next;
	lec_pkg::lec_fl_s            fl_reg;
	lec_pkg::lec_fl_s            fl_next;
	// answers and settings towards the pins
	lec_pkg::lec_chk_s           chk_reg;
	lec_pkg::lec_chk_s           chk_next;
	logic                        wait_reg;
	logic                        wait_next;
	logic [31:0]                 rdata_reg;
	logic [31:0]                 rdata_next;
	lec_pkg::lec_cfg_s           cfg_reg;
	lec_pkg::lec_cfg_s           cfg_next;

	// =============================================================
	// bus decode

	wire       hit_ctl1  = lec_hit(i_address, `LEC_CTL1_IDX);
	wire       hit_ctl2  = lec_hit(i_address, `LEC_CTL2_IDX);
	wire       hit_msel  = lec_hit(i_address, `LEC_MSEL_IDX);
	// write lands only on the edge where waitrequest is low
	wire       wr_fire   = i_write & ~wait_reg & i_byteenable[0];
	wire       wr_ctl1   = wr_fire & hit_ctl1;
	wire       wr_ctl2   = wr_fire & hit_ctl2;
	wire       wr_msel   = wr_fire & hit_msel;
	// one byte register per word, so only the low lane is looked at
	wire [7:0] wdat      = i_writedata[7:0];

	// =============================================================
	// flush scheduling

	wire [1:0] scope      = ctl2_reg[`LEC_SCOPE_LO +: 2];
	wire [1:0] scope_kinds = lec_scope_kinds(scope);
	wire       scope_none = (scope == `LEC_SCOPE_NONE);
	wire       idle       = (st_reg == lec_pkg::LEC_IDLE);
	wire       step_done  = fl_reg.valid & i_flush_ack;
	wire       walk_last  = step_done & (fl_reg.idx == LAST_IDX);

	// table flush first, then spanning tree, then link down
	// a request of another kind waits in its pending bit; a table or spanning tree repeat before its walk's last step merges into that walk
	wire       start_tbl  = idle & tbl_pend_reg;
	wire       start_mstp = idle & ~tbl_pend_reg & mstp_pend_reg;
	wire       start_link = idle & ~tbl_pend_reg & ~mstp_pend_reg & (|ld_pend_reg);

	// scope 00 has nothing to remove, so the trigger finishes at once
	wire       done_tbl   = (start_tbl & scope_none)                            // see R12
	                      | (walk_last & (kind_reg == lec_pkg::LEC_K_TBL));     // see R4
	wire       done_mstp  = (start_mstp & scope_none)                           // see R12
	                      | (walk_last & (kind_reg == lec_pkg::LEC_K_MSTP));    // see R7
	wire       walk_start = ((start_tbl | start_mstp) & ~scope_none) | start_link;

	// writing 1 arms a trigger; writing 0 changes nothing
	wire       set_tbl    = wr_ctl1 & wdat[`LEC_B_FLUSH_TBL];                   // see R4
	wire       set_mstp   = wr_ctl1 & wdat[`LEC_B_FLUSH_MSTP];                  // see R7

	// link down events are caught only while the link flush is enabled
	wire [`LEC_PORTS-1:0] ld_in   = ctl1_reg[`LEC_B_LINK_FLUSH] ? i_link_down : '0;    // see R11
	// the mask is cleared as the walker takes it; fresh events land again
	wire [`LEC_PORTS-1:0] ld_take = start_link ? ld_pend_reg : '0;

	// =============================================================
	// register next values

	// control one keeps plain bits; trigger bits live in the pending flags
	assign ctl1_next = wr_ctl1
	                 ? {wdat[7:6], 2'b00, wdat[3:0]}    // see R1 R2 R8 R9 R10 R11
	                 : ctl1_reg;
	assign ctl2_next = wr_ctl2 ? wdat : ctl2_reg;
	assign msel_next = wr_msel ? wdat[`LEC_MSTI_W-1:0] : msel_reg;

	// table settings follow the value the register takes at the same edge
	assign cfg_next = {~ctl1_next[`LEC_B_LEARN_DIS],    // see R1
	                   ctl1_next[`LEC_B_AGE_EN],        // see R9
	                   ctl1_next[`LEC_B_FAST_AGE]};     // see R10

	// set wins over the clear of a finishing flush
	assign tbl_pend_next  = set_tbl  | (tbl_pend_reg  & ~done_tbl);    // see R13
	assign mstp_pend_next = set_mstp | (mstp_pend_reg & ~done_mstp);   // see R13
	assign ld_pend_next   = ld_in | (ld_pend_reg & ~ld_take);          // see R11

	// =============================================================
	// flush walker

	always_comb
	begin
		st_next   = st_reg;
		kind_next = kind_reg;
		fl_next   = fl_reg;
		unique case (st_reg)
			// idle: start the highest pending flush
			lec_pkg::LEC_IDLE:
			begin
				if (walk_start)
				begin
					st_next       = lec_pkg::LEC_WALK;
					fl_next.valid = 1'b1;
					fl_next.idx   = '0;
					// scope is taken once here; a rewrite during a walk waits for the next trigger
					fl_next.dyn   = start_link | scope_kinds[0];  // see R5 R12
					// static entries of this table only; a separate static table lies outside
					fl_next.stat  = ~start_link & scope_kinds[1]; // see R5 R6 R12
					fl_next.by_msti = start_mstp;                 // see R7
					fl_next.msti  = msel_reg;
					fl_next.by_port = start_link;                 // see R11
					fl_next.ports = ld_pend_reg;
					if (start_tbl)
					begin
						kind_next = lec_pkg::LEC_K_TBL;
					end
					else if (start_mstp)
					begin
						kind_next = lec_pkg::LEC_K_MSTP;
					end
					else
					begin
						kind_next = lec_pkg::LEC_K_LINK;
					end
				end
			end
			// walk: one entry per accepted step
			lec_pkg::LEC_WALK:
			begin
				if (walk_last)
				begin
					st_next       = lec_pkg::LEC_IDLE;
					fl_next.valid = 1'b0;
				end
				else if (step_done)
				begin
					fl_next.idx = fl_reg.idx + `LEC_ENT_W'(1);
				end
			end
		endcase
	end

	// =============================================================
	// source address checks

	// group bit of the first octet marks a multicast source
	wire sa_mc    = i_pkt.sa[`LEC_SA_MC_BIT];
	wire self_hit = ctl1_reg[`LEC_B_SELF_FILT]                      // see R2
	              & i_sa_filt_port_en[i_pkt.port]                    // see R3
	              & (i_pkt.sa == i_self_mac);                        // see R2
	wire mc_drop  = sa_mc & ~ctl1_reg[`LEC_B_MC_SA_FWD];            // see R8
	wire pkt_drop = self_hit | mc_drop;

	// multicast sources are never learned, whatever the learning bit says
	wire chk_drop  = i_pkt.valid & pkt_drop;
	wire chk_learn = i_pkt.valid & ~pkt_drop & ~sa_mc
	               & ~ctl1_reg[`LEC_B_LEARN_DIS];                   // see R1
	assign chk_next = {i_pkt.valid, chk_drop, chk_learn};

	// =============================================================
	// bus answer

	// trigger bits read back busy until the flush is over
	wire [7:0] ctl1_rd = {ctl1_reg[7:6], tbl_pend_reg, mstp_pend_reg, ctl1_reg[3:0]};    // see R13

	// unmapped words read as zero
	wire [7:0] rd_sel  = hit_ctl1 ? ctl1_rd
	                   : hit_ctl2 ? ctl2_reg
	                   : hit_msel ? {{(8-`LEC_MSTI_W){1'b0}}, msel_reg}
	                   : 8'h00;

	// one wait cycle, then one answer cycle
	// the registered answer costs a cycle but keeps decode off the readdata path
	assign wait_next  = ~((i_read | i_write) & wait_reg);
	assign rdata_next = (i_read & wait_reg) ? {24'h000000, rd_sel} : rdata_reg;

	// =============================================================
	// flip-flops

	// registers and flags
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ctl1_reg      <= `LEC_CTL1_RST;
			ctl2_reg      <= `LEC_CTL2_RST;
			msel_reg      <= '0;
			tbl_pend_reg  <= 1'b0;
			mstp_pend_reg <= 1'b0;
			ld_pend_reg   <= '0;
		end
		else
		begin
			ctl1_reg      <= ctl1_next;
			ctl2_reg      <= ctl2_next;
			msel_reg      <= msel_next;
			tbl_pend_reg  <= tbl_pend_next;
			mstp_pend_reg <= mstp_pend_next;
			ld_pend_reg   <= ld_pend_next;
		end
	end

	// walker
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_reg   <= lec_pkg::LEC_IDLE;
			kind_reg <= lec_pkg::LEC_K_TBL;
			fl_reg   <= '0;
		end
		else
		begin
			st_reg   <= st_next;
			kind_reg <= kind_next;
			fl_reg   <= fl_next;
		end
	end

	// table settings
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cfg_reg <= `LEC_CFG_RST;
		end
		else
		begin
			cfg_reg <= cfg_next;
		end
	end

	// packet check answer
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			chk_reg <= '0;
		end
		else
		begin
			chk_reg <= chk_next;
		end
	end

	// bus answer
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// =============================================================
	// outputs

	assign o_readdata     = rdata_reg;
	assign o_waitrequest  = wait_reg;
	assign o_chk          = chk_reg;
	assign o_flush        = fl_reg;
	assign o_cfg          = cfg_reg;                        // see R1 R9 R10

endmodule

// ### testbench/lec_ctrl_one_sva.sv
/* port checker for lec_ctrl_one
 assumes the bind below reaches every instance */
`timescale 1ns/10ps
`include "lec_cfg.svh"
// ====
// packet and walker relations
module lec_ctrl_one_chk
#(
	parameter int ENTRIES = `LEC_ENTRIES
)
(
	input wire logic                  i_mclk,
	input wire logic                  i_nrst,
	input wire logic [47:0]           i_self_mac,
	input wire logic [`LEC_PORTS-1:0] i_sa_filt_port_en,
	input wire lec_pkg::lec_pkt_s     i_pkt,
	input wire lec_pkg::lec_chk_s     o_chk,
	input wire lec_pkg::lec_cfg_s     o_cfg,
	input wire lec_pkg::lec_fl_s      o_flush,
	input wire logic                  i_flush_ack
);
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);
	chk_learn_off: assert property (i_pkt.valid && !o_cfg.learn_en |=> !o_chk.learn)
		else $error("learned while off");
	chk_mc_nolearn: assert property (i_pkt.valid && i_pkt.sa[40] |=> o_chk.valid && !o_chk.learn)
		else $error("multicast source learned");
	chk_self_only: assert property (i_pkt.valid && !i_pkt.sa[40] && i_pkt.sa != i_self_mac |=> !o_chk.drop)
		else $error("drop without match");
	chk_port_gate: assert property (i_pkt.valid && !i_pkt.sa[40] && !i_sa_filt_port_en[i_pkt.port]
		|=> !o_chk.drop)
		else $error("drop on port without enable");
	chk_step_hold: assert property (o_flush.valid && !i_flush_ack |=> o_flush.valid && $stable(o_flush.idx))
		else $error("step moved without ack");
	chk_step_next: assert property (o_flush.valid && i_flush_ack && o_flush.idx != ENTRIES - 1
		|=> o_flush.valid && o_flush.idx == $past(o_flush.idx) + 1'b1)
		else $error("step not advanced");
	chk_walk_end: assert property (o_flush.valid && i_flush_ack && o_flush.idx == ENTRIES - 1
		|=> !o_flush.valid)
		else $error("walk ran past end");
	chk_link_dyn: assert property (o_flush.valid && o_flush.by_port |-> o_flush.dyn && !o_flush.stat)
		else $error("link flush kind wrong");
	chk_scope_some: assert property (o_flush.valid |-> o_flush.dyn || o_flush.stat)
		else $error("walk with empty scope");
endmodule

bind lec_ctrl_one lec_ctrl_one_chk #(.ENTRIES(ENTRIES)) u_chk (.i_mclk, .i_nrst, .i_self_mac,
	.i_sa_filt_port_en, .i_pkt, .o_chk, .o_cfg, .o_flush, .i_flush_ack);

// ### testbench/test_lec_ctrl_one.sv
/* bench for lec_ctrl_one: registers, packet checks, flushes
 assumes lec_pkg and the checker are compiled first */
`timescale 1ns/10ps
// ====
// stimulus and checks
module test_lec_ctrl_one;
	localparam int N = 16;
	logic              i_mclk = 0;
	logic              i_nrst = 0;
	logic [11:0]       i_address = 0;
	logic              i_read = 0;
	logic              i_write = 0;
	logic [31:0]       i_writedata = 0;
	logic [31:0]       o_readdata;
	logic              o_waitrequest;
	logic [47:0]       i_self_mac = 0;
	logic [7:0]        i_sa_filt_port_en = 0;
	logic [7:0]        i_link_down = 0;
	logic              i_flush_ack = 0;
	lec_pkg::lec_pkt_s i_pkt = '0;
	lec_pkg::lec_chk_s o_chk;
	lec_pkg::lec_cfg_s o_cfg;
	lec_pkg::lec_fl_s  o_flush;
	lec_pkg::lec_fl_s  seen;
	lec_pkg::lec_pkt_s p;
	logic [31:0]       seed = 32'h3BE22759;
	logic [31:0]       rv;
	logic [7:0]        c1;
	logic [7:0]        lm;
	logic [3:0]        m;
	int                miscompares = 0;
	int                checks_done = 0;
	int                steps = 0;

	lec_ctrl_one #(.ENTRIES(N)) u_dut (.i_mclk, .i_nrst, .i_address, .i_read, .i_write,
		.i_byteenable(4'hF), .i_writedata, .o_readdata, .o_waitrequest, .i_self_mac,
		.i_sa_filt_port_en, .i_link_down, .i_pkt, .o_chk, .o_cfg, .o_flush, .i_flush_ack);

	always #2.5 i_mclk = ~i_mclk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// table acks at random, stalls included
	always @(posedge i_mclk) i_flush_ack <= rnd() % 3 != 0;

	// walk monitor: last step seen, steps taken
	always @(posedge i_mclk)
	begin
		if (o_flush.valid) seen <= o_flush;
		if (o_flush.valid && i_flush_ack) steps++;
	end

	task automatic ck(input string n, input logic [47:0] e, input logic [47:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s exp %0h got %0h", n, e, g);
		end
	endtask

	// one avalon access, held until waitrequest low
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_address <= a;
		i_writedata <= {24'h000000, d};
		i_write <= w;
		i_read <= !w;
		do @(posedge i_mclk); while (o_waitrequest);
		rv = o_readdata;
		i_write <= 1'h0;
		i_read <= 1'h0;
	endtask

	function automatic logic [1:0] ex(input lec_pkg::lec_pkt_s q);
		logic d;
		d = (c1[6] & i_sa_filt_port_en[q.port] & (q.sa == i_self_mac)) | (q.sa[40] & ~c1[3]);
		return {d, ~d & ~q.sa[40] & ~c1[7]};
	endfunction

	task automatic pk(input lec_pkg::lec_pkt_s q);
		logic [1:0] e;
		@(posedge i_mclk);
		i_pkt <= q;
		e = ex(q);
		@(posedge i_mclk);
		i_pkt.valid <= 1'h0;
		@(posedge i_mclk);
		ck("valid", 1'h1, o_chk.valid);
		ck("drop", e[1], o_chk.drop);
		ck("learn", e[0], o_chk.learn);
	endtask

	// trigger one flush kind with one scope, follow the walk
	task automatic fl(input int b, input logic [1:0] s);
		bus(1'h1, 12'hC48, {4'h0, s, 2'h0});
		steps = 0;
		bus(1'h1, 12'hC44, 8'h0C | (8'h01 << b));
		bus(1'h0, 12'hC44, 8'h00);
		ck("busy", s != 0, rv[b]);
		repeat (300) @(posedge i_mclk) if (!o_flush.valid && (steps >= N || s == 0)) break;
		ck("steps", s != 0 ? N : 0, steps);
		if (s != 0) ck("scope", s, {seen.stat, seen.dyn});
		if (s != 0) ck("msti", {b == 4, m}, {seen.by_msti, seen.msti});
		bus(1'h0, 12'hC44, 8'h00);
		ck("done", 8'h0C, rv);
	endtask

	task automatic results();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#(5 * 20000);
		miscompares++;
		results();
	end

	initial
	begin
		repeat (5) @(posedge i_mclk);
		i_nrst <= 1'h1;
		bus(1'h0, 12'hC44, 8'h00);
		ck("ctl1", 8'h0C, rv);
		ck("cfg", 3'h6, o_cfg);
		bus(1'h0, 12'hC48, 8'h00);
		ck("ctl2", 8'h00, rv);
		bus(1'h0, 12'h000, 8'h00);
		ck("unmapped", 32'h0, rv);
		$display("test reset done");
		i_self_mac <= 48'({rnd(), rnd()});
		for (int i = 0; i < 6; i++)
		begin
			// two fixed corners first: learning off with multicast drop, then filtering alone
			c1 = (i == 0) ? 8'hC3 : (i == 1) ? 8'h48 : 8'(rnd()) & 8'hCF;
			bus(1'h1, 12'hC44, c1);
			bus(1'h0, 12'hC44, 8'h00);
			ck("readback", c1, rv);
			ck("cfg", {~c1[7], c1[2], c1[1]}, o_cfg);
			i_sa_filt_port_en <= 8'(rnd());
			repeat (8)
			begin
				p = {1'h1, 51'({rnd(), rnd()})};
				if (p.sa[0]) p.sa = i_self_mac ^ {7'h00, p.port[0], 40'h0};
				pk(p);
			end
		end
		$display("test packets done");
		m = 4'(rnd());
		bus(1'h1, 12'hC7C, {4'h0, m});
		for (int b = 4; b < 6; b++)
			for (int s = 0; s < 4; s++)
				fl(b, 2'(s));
		$display("test flush done");
		for (int e = 1; e >= 0; e--)
		begin
			bus(1'h1, 12'hC44, {7'h06, e[0]});
			steps = 0;
			lm = 8'(rnd()) | 8'h01;
			@(posedge i_mclk);
			i_link_down <= lm;
			@(posedge i_mclk);
			i_link_down <= 8'h00;
			repeat (e ? 300 : 40) @(posedge i_mclk) if (e && !o_flush.valid && steps >= N) break;
			ck("link steps", e ? N : 0, steps);
			if (e) ck("link kind", {lm, 3'h6}, {seen.ports, seen.by_port, seen.dyn, seen.stat});
		end
		$display("test link done");
		results();
	end
endmodule
